// [fcor_top.sv]
// How it works
// - loaded flag: reset clears, first write sets
// - low seven bits readable, written once
// - erase/program refused until flag set
// - prescale bit selects bus or bus/8
// - timing clock is input over ratio+1
// - each timing pulse lasts one bus cycle unless ratio is zero without prescale, where tick stays high
// - operations last whole numbers of pulses
// - option byte copied into shadow at reset
// - shadow bits five to two read zero
// - shadow readable, writes change nothing
// - eight-bit registers, reset-loaded option copy
// - security code 1:0 alone means unsecured
// - bit six one disables vector remap
// - bit seven zero blocks backdoor unlock
`timescale 1ns/1ns
`default_nettype none
module fcor_top #(
   parameter int RATIO_W = fcor_pkg::RATIO_W
) (
   input  wire logic       clk_in,
   input  wire logic       rst_n_in,
   input  wire logic [7:0] stored_option_byte_in,
   input  wire logic [3:0] addr_in,
   input  wire logic [7:0] wdata_in,
   input  wire logic       wr_in,
   input  wire logic       rd_in,
   output logic      [7:0] rdata_out,
   output logic            flash_timing_tick_out,
   output logic            prog_pulse_out,
   output logic            op_busy_out,
   output logic            secured_out,
   output logic            vector_remap_en_out,
   output logic            backdoor_allowed_out
);
   logic         ratio_loaded_flag_q, ratio_loaded_flag_d;
   logic         prescale_eighth_q, prescale_eighth_d;
   logic [RATIO_W-1:0] ratio_q, ratio_d;
   logic [7:0]   opt_q, opt_d;
   logic         opt_loaded_q, opt_loaded_d;
   logic [2:0]   pre_q, pre_d;
   logic [7:0]   op_len_q, op_len_d;
   logic [7:0]   pulse_left_q, pulse_left_d;
   logic [7:0]   pulse_done_q, pulse_done_d;
   logic         refused_q, refused_d;
   fcor_pkg::fcor_op_t st_q, st_d;
   logic [7:0]   rdata_q, rdata_d;
   logic         step;
   logic         tick;
   logic         start_req;

   // bus/8 enable from a free counter, only used when prescaling
   assign step = !prescale_eighth_q ||
                 (pre_q == 3'(fcor_pkg::PRESCALE_DIV - 1));
   assign start_req = wr_in && (addr_in == fcor_pkg::OP_CTRL_OFS) &&
                      wdata_in[fcor_pkg::OP_START_BIT];

   fcor_divider #(
      .W (RATIO_W)
   ) fcor_divider_i (
      .clk_in   (clk_in),
      .rst_n_in (rst_n_in),
      .run_in   (ratio_loaded_flag_q),
      .step_in  (step),
      .ratio_in (ratio_q),
      .tick_out (tick)
   );

   // divider config register: single write after reset
   always_comb begin
      ratio_loaded_flag_d = ratio_loaded_flag_q;
      prescale_eighth_d   = prescale_eighth_q;
      ratio_d             = ratio_q;
      pre_d               = pre_q + 3'd1;
      if (wr_in && addr_in == fcor_pkg::TICK_CFG_OFS && !ratio_loaded_flag_q) begin
         ratio_loaded_flag_d = 1'b1;
         prescale_eighth_d   = wdata_in[fcor_pkg::PRESCALE_BIT];
         ratio_d             = wdata_in[RATIO_W-1:0];
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         ratio_loaded_flag_q <= fcor_pkg::TICK_CFG_RST[fcor_pkg::LOADED_BIT];
         prescale_eighth_q   <= fcor_pkg::TICK_CFG_RST[fcor_pkg::PRESCALE_BIT];
         ratio_q             <= '0;
         pre_q               <= 3'd0;
      end else begin
         ratio_loaded_flag_q <= ratio_loaded_flag_d;
         prescale_eighth_q   <= prescale_eighth_d;
         ratio_q             <= ratio_d;
         pre_q               <= pre_d;
      end
   end

   // option shadow: tracks the stored byte while reset is held,
   // caught once more on the first clock after release
   always_comb begin
      opt_d        = opt_q;
      opt_loaded_d = 1'b1;
      if (!opt_loaded_q) begin
         opt_d = stored_option_byte_in & fcor_pkg::OPT_IMPL_MASK;
      end
   end

   // no write path exists to the shadow at all
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         opt_q        <= stored_option_byte_in & fcor_pkg::OPT_IMPL_MASK;
         opt_loaded_q <= 1'b0;
      end else begin
         opt_q        <= opt_d;
         opt_loaded_q <= opt_loaded_d;
      end
   end

   // operation sequencer: runs a whole number of timing pulses
   always_comb begin
      st_d         = st_q;
      op_len_d     = op_len_q;
      pulse_left_d = pulse_left_q;
      pulse_done_d = pulse_done_q;
      refused_d    = refused_q;
      if (wr_in && addr_in == fcor_pkg::PULSE_CNT_OFS) begin
         op_len_d = wdata_in;
      end
      unique case (st_q)
         fcor_pkg::FCOR_IDLE: begin
            if (start_req) begin
               if (!ratio_loaded_flag_q) begin
                  refused_d = 1'b1;
               end else begin
                  refused_d    = 1'b0;
                  pulse_left_d = op_len_q;
                  pulse_done_d = 8'h00;
                  st_d         = fcor_pkg::FCOR_RUN;
               end
            end
         end
         fcor_pkg::FCOR_RUN: begin
            if (pulse_left_q == 8'h00) begin
               st_d = fcor_pkg::FCOR_IDLE;
            end else if (tick) begin
               pulse_left_d = pulse_left_q - 8'd1;
               pulse_done_d = pulse_done_q + 8'd1;
            end
         end
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         st_q         <= fcor_pkg::FCOR_IDLE;
         op_len_q     <= fcor_pkg::OP_PULSES_RST;
         pulse_left_q <= 8'h00;
         pulse_done_q <= 8'h00;
         refused_q    <= 1'b0;
      end else begin
         st_q         <= st_d;
         op_len_q     <= op_len_d;
         pulse_left_q <= pulse_left_d;
         pulse_done_q <= pulse_done_d;
         refused_q    <= refused_d;
      end
   end

   // read mux, data in the cycle after the strobe
   always_comb begin
      rdata_d = 8'h00;
      if (rd_in) begin
         unique case (addr_in)
            fcor_pkg::TICK_CFG_OFS:
               rdata_d = {ratio_loaded_flag_q, prescale_eighth_q, 6'(ratio_q)};
            fcor_pkg::OPT_SHADOW_OFS: rdata_d = opt_q;
            fcor_pkg::STATUS_OFS: begin
               rdata_d[fcor_pkg::ST_BUSY_BIT]    = (st_q == fcor_pkg::FCOR_RUN);
               rdata_d[fcor_pkg::ST_REFUSED_BIT] = refused_q;
               rdata_d[fcor_pkg::ST_SECURE_BIT]  = secured_out;
               rdata_d[fcor_pkg::ST_REMAP_BIT]   = vector_remap_en_out;
               rdata_d[fcor_pkg::ST_KEY_BIT]     = backdoor_allowed_out;
               rdata_d[fcor_pkg::ST_LOADED_BIT]  = ratio_loaded_flag_q;
            end
            fcor_pkg::PULSE_CNT_OFS: rdata_d = op_len_q;
            default: rdata_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign rdata_out             = rdata_q;
   assign flash_timing_tick_out = tick;
   assign prog_pulse_out        = (st_q == fcor_pkg::FCOR_RUN) && tick &&
                                  (pulse_left_q != 8'h00);
   assign op_busy_out           = (st_q == fcor_pkg::FCOR_RUN);
   // decoded option bits
   assign secured_out          = (opt_q[1:0] != fcor_pkg::SEC_OPEN_CODE);
   assign vector_remap_en_out  = !opt_q[fcor_pkg::NORED_BIT];
   assign backdoor_allowed_out = opt_q[fcor_pkg::UNLOCK_EN_BIT];

   // check helper: bus cycles since the last tick, saturating so an idle
   // divider never wraps round into a false match
   logic [9:0] gap_q;
   logic [9:0] gap_d;
   logic [9:0] gap_want;
   logic       tick_seen_q;
   logic       tick_seen_d;

   // first tick after load has an arbitrary prescale phase, so it is skipped
   always_comb begin
      gap_d       = gap_q;
      tick_seen_d = tick_seen_q || tick;
      gap_want    = 10'(ratio_q) + 10'd1;
      if (prescale_eighth_q) begin
         gap_want = gap_want * 10'(fcor_pkg::PRESCALE_DIV);
      end
      if (tick) begin
         gap_d = 10'd1;
      end else if (gap_q != 10'h3FF) begin
         gap_d = gap_q + 10'd1;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         gap_q       <= 10'h000;
         tick_seen_q <= 1'b0;
      end else begin
         gap_q       <= gap_d;
         tick_seen_q <= tick_seen_d;
      end
   end

   // assertions
   sequence s_cfg_write;
      wr_in && addr_in == fcor_pkg::TICK_CFG_OFS;
   endsequence

   sequence s_start_ok;
      start_req && ratio_loaded_flag_q && !op_busy_out;
   endsequence

   flag_set_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      s_cfg_write |=> ratio_loaded_flag_q)
      else $error("loaded flag not set by write");
   once_only_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      ratio_loaded_flag_q |=> $stable(ratio_q) && $stable(prescale_eighth_q))
      else $error("divider config changed twice");
   refuse_op_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      start_req && !ratio_loaded_flag_q |=> refused_q && !op_busy_out)
      else $error("operation started before config");
   tick_gap_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      tick && !prescale_eighth_q && $stable(ratio_q) && ratio_q == '0 |=> tick)
      else $error("ratio zero did not tick each cycle");
   pre_gap_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      tick && prescale_eighth_q |=> !tick [*7])
      else $error("prescaled tick too close");
   pulse_tick_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      prog_pulse_out |-> tick && op_busy_out)
      else $error("pulse outside a tick");
   op_count_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      $fell(op_busy_out) |-> pulse_done_q == $past(op_len_q, 1) || $changed(op_len_q))
      else $error("operation pulse count wrong");
   opt_zero_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      rd_in && addr_in == fcor_pkg::OPT_SHADOW_OFS |=> rdata_out[5:2] == 4'h0)
      else $error("unused option bits not zero");
   opt_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      opt_loaded_q |=> $stable(opt_q))
      else $error("option shadow changed");
   sec_dec_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      !secured_out |-> opt_q[1] && !opt_q[0])
      else $error("security decode wrong");
   tick_period_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      tick && tick_seen_q |-> gap_q == gap_want)
      else $error("timing tick period wrong");
   tick_held_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      !ratio_loaded_flag_q |-> !tick)
      else $error("tick before divider loaded");
   tick_single_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      tick && (prescale_eighth_q || ratio_q != '0) |=> !tick)
      else $error("timing pulse longer than one cycle");
   start_busy_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      s_start_ok |=> op_busy_out && !refused_q)
      else $error("accepted start did not run");
   refuse_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      refused_q && !start_req |=> refused_q)
      else $error("refused flag lost");
   empty_op_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      s_start_ok ##0 (op_len_q == 8'h00) |=> op_busy_out && !prog_pulse_out ##1 !op_busy_out)
      else $error("empty operation wrong");
   opt_load_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      !opt_loaded_q |=>
         opt_q == ($past(stored_option_byte_in) & fcor_pkg::OPT_IMPL_MASK))
      else $error("option byte not captured");
   rd_idle_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      !rd_in |=> rdata_out == 8'h00)
      else $error("read data outside its cycle");
endmodule : fcor_top
`default_nettype wire

// [fcor_pkg.sv]
package fcor_pkg;
   // register offsets on the plain register port
   localparam logic [3:0] TICK_CFG_OFS   = 4'h0;
   localparam logic [3:0] OPT_SHADOW_OFS = 4'h1;
   localparam logic [3:0] STATUS_OFS     = 4'h2;
   localparam logic [3:0] OP_CTRL_OFS    = 4'h3;
   localparam logic [3:0] PULSE_CNT_OFS  = 4'h4;
   // tick config fields
   localparam int LOADED_BIT    = 7;
   localparam int PRESCALE_BIT  = 6;
   localparam int RATIO_MSB     = 5;
   localparam int RATIO_W       = 6;
   localparam logic [7:0] TICK_CFG_RST = 8'h00;
   // option shadow fields
   localparam int UNLOCK_EN_BIT = 7;
   localparam int NORED_BIT     = 6;
   localparam logic [7:0] OPT_IMPL_MASK = 8'hC3;
   localparam logic [1:0] SEC_OPEN_CODE = 2'h2;
   // prescale ratio and operation length
   localparam int PRESCALE_DIV  = 8;
   localparam logic [7:0] OP_PULSES_RST = 8'h00;
   // op control bits
   localparam int OP_START_BIT  = 0;
   // status bits
   localparam int ST_BUSY_BIT   = 0;
   localparam int ST_REFUSED_BIT = 1;
   localparam int ST_SECURE_BIT = 2;
   localparam int ST_REMAP_BIT  = 3;
   localparam int ST_KEY_BIT    = 4;
   localparam int ST_LOADED_BIT = 5;
   typedef enum logic [0:0] {
      FCOR_IDLE = 1'b0,
      FCOR_RUN  = 1'b1
   } fcor_op_t;
endpackage : fcor_pkg

// [fcor_divider.sv]
`timescale 1ns/1ns
`default_nettype none
// counts input enables down, reloads ratio, one tick at zero
module fcor_divider #(
   parameter int W = 6
) (
   input  wire logic         clk_in,
   input  wire logic         rst_n_in,
   input  wire logic         run_in,
   input  wire logic         step_in,
   input  wire logic [W-1:0] ratio_in,
   output logic              tick_out
);
   logic [W-1:0] cnt_q;
   logic [W-1:0] cnt_d;
   logic         tick_q;
   logic         tick_d;

   // reload on zero so the period is ratio plus one steps
   always_comb begin
      cnt_d  = cnt_q;
      tick_d = 1'b0;
      if (!run_in) begin
         cnt_d = ratio_in;
      end else if (step_in) begin
         if (cnt_q == '0) begin
            cnt_d  = ratio_in;
            tick_d = 1'b1;
         end else begin
            cnt_d = cnt_q - 1'b1;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         cnt_q  <= '0;
         tick_q <= 1'b0;
      end else begin
         cnt_q  <= cnt_d;
         tick_q <= tick_d;
      end
   end

   assign tick_out = tick_q;
endmodule : fcor_divider
`default_nettype wire

// [fcor_top_test.sv]
`timescale 1ns/1ns
`default_nettype none
// one compare: counts it, reports a mismatch at once
`define CHECK(what, exp, got) \
   begin \
      samples_checked++; \
      if ((got) !== (exp)) begin \
         num_errors++; \
         $display("wrong value %s expected %h seen %h", what, exp, got); \
      end \
   end
module fcor_top_test;
   logic       clk_in                = 1'b0;
   logic       rst_n_in              = 1'b0;
   logic [7:0] stored_option_byte_in = 8'h02;
   logic [3:0] addr_in               = 4'h0;
   logic [7:0] wdata_in              = 8'h00;
   logic       wr_in                 = 1'b0;
   logic       rd_in                 = 1'b0;
   logic [7:0] rdata_out;
   logic       flash_timing_tick_out;
   logic       prog_pulse_out;
   logic       op_busy_out;
   logic       secured_out;
   logic       vector_remap_en_out;
   logic       backdoor_allowed_out;
   int         num_errors            = 0;
   int         samples_checked       = 0;

   fcor_top fcor_top_i (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .stored_option_byte_in(stored_option_byte_in),
      .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
      .rdata_out(rdata_out), .flash_timing_tick_out(flash_timing_tick_out),
      .prog_pulse_out(prog_pulse_out), .op_busy_out(op_busy_out),
      .secured_out(secured_out), .vector_remap_en_out(vector_remap_en_out),
      .backdoor_allowed_out(backdoor_allowed_out));

   // 100 MHz bus clock
   always #5 clk_in = ~clk_in;

   // reset for 20 cycles with a given option byte in the store
   task automatic do_reset(input logic [7:0] opt);
      @(posedge clk_in);
      rst_n_in <= 1'b0;
      stored_option_byte_in <= opt;
      repeat (20) @(posedge clk_in);
      rst_n_in <= 1'b1;
   endtask : do_reset

   // single-cycle write strobe
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask : wr_reg

   // read data stands only in the cycle after the strobe
   task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1 d = rdata_out;
   endtask : rd_reg

   // cycles between two timing ticks, bounded so a dead divider cannot hang
   task automatic tick_gap(output int n);
      int i;
      n = 0;
      for (i = 0; i < 600 && flash_timing_tick_out !== 1'b1; i++) begin
         @(posedge clk_in);
         #1;
      end
      do begin
         @(posedge clk_in);
         #1;
         n++;
      end while (flash_timing_tick_out !== 1'b1 && n < 600);
   endtask : tick_gap

   // every security code and both option flags, bits 5:2 set in the store
   task automatic test_options();
      logic [7:0] opt;
      logic [7:0] d;
      for (int k = 0; k < 4; k++) begin
         opt = {k[0], k[1], 4'hF, k[1:0]};
         do_reset(opt);
         rd_reg(4'h1, d);
         `CHECK("option shadow", opt & 8'hC3, d)
         `CHECK("secured", (k != 2), secured_out)
         `CHECK("remap enable", ~k[1], vector_remap_en_out)
         `CHECK("backdoor allowed", k[0], backdoor_allowed_out)
         // a new stored byte must wait for the next reset
         @(posedge clk_in);
         stored_option_byte_in <= ~opt;
         wr_reg(4'h1, ~opt);
         rd_reg(4'h1, d);
         `CHECK("shadow after write", opt & 8'hC3, d)
      end
      rd_reg(4'hF, d);
      `CHECK("unmapped read", 8'h00, d)
   endtask : test_options

   // refused before load, write-once divider, period, whole pulse count
   task automatic test_load_and_op();
      logic [7:0] d;
      int         n;
      int         pulses;
      do_reset(8'h02);
      rd_reg(4'h0, d);
      `CHECK("config after reset", 8'h00, d)
      wr_reg(4'h4, 8'h03);
      rd_reg(4'h4, d);
      `CHECK("operation length", 8'h03, d)
      wr_reg(4'h3, 8'h01);
      repeat (3) @(posedge clk_in);
      #1 `CHECK("busy while unloaded", 1'b0, op_busy_out)
      rd_reg(4'h2, d);
      `CHECK("status refused", 8'h0A, d)
      wr_reg(4'h0, 8'h05);
      rd_reg(4'h0, d);
      `CHECK("config loaded", 8'h85, d)
      wr_reg(4'h0, 8'h7A);
      rd_reg(4'h0, d);
      `CHECK("config second write", 8'h85, d)
      tick_gap(n);
      `CHECK("tick period", 6, n)
      wr_reg(4'h3, 8'h01);
      // busy rises in the cycle right after the start strobe
      #1 `CHECK("busy after start", 1'b1, op_busy_out)
      pulses = 0;
      for (n = 0; n < 200 && op_busy_out === 1'b1; n++) begin
         if (prog_pulse_out === 1'b1) begin
            pulses++;
            `CHECK("pulse on tick", 1'b1, flash_timing_tick_out)
         end
         @(posedge clk_in);
         #1;
      end
      `CHECK("pulse count", 3, pulses)
      rd_reg(4'h2, d);
      `CHECK("status after op", 8'h28, d)
      // an empty operation: one busy cycle and no pulse
      wr_reg(4'h4, 8'h00);
      wr_reg(4'h3, 8'h01);
      #1 `CHECK("busy empty op", 1'b1, op_busy_out)
      `CHECK("no pulse empty op", 1'b0, prog_pulse_out)
      @(posedge clk_in);
      #1 `CHECK("idle after empty op", 1'b0, op_busy_out)
   endtask : test_load_and_op

   // prescale by eight stretches the period eightfold; the last setting
   // keeps the timing clock inside its legal band at a 100 MHz bus
   task automatic test_prescale();
      logic [7:0] d;
      int         n;
      do_reset(8'h02);
      wr_reg(4'h0, 8'h41);
      tick_gap(n);
      tick_gap(n);
      `CHECK("prescaled period", 16, n)
      do_reset(8'h02);
      wr_reg(4'h0, 8'h00);
      rd_reg(4'h0, d);
      `CHECK("zero write loads", 8'h80, d)
      tick_gap(n);
      tick_gap(n);
      `CHECK("ratio zero period", 1, n)
      do_reset(8'h02);
      wr_reg(4'h0, 8'h7E);
      tick_gap(n);
      tick_gap(n);
      `CHECK("in-band period", 504, n)
   endtask : test_prescale

   // verdict and end of run, shared with the watchdog
   task automatic stop_test();
      $display("errors %0d checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : stop_test

   // main sequence
   initial begin
      test_options();
      test_load_and_op();
      test_prescale();
      stop_test();
   end

   // watchdog: the tests need well under 3000 cycles
   initial begin
      repeat (20000) @(posedge clk_in);
      num_errors++;
      stop_test();
   end
endmodule : fcor_top_test
`default_nettype wire
